// file: rtl/olm_frame_map.sv
// Frame memory of 128x128 pixels at 4 bits, written over APB and scanned
// out to the panel drive outputs one byte (two pixels) per clock.
// Assumes an APB master in the pclk domain; panel reset is presetn.
`timescale 1ns/1ps

// How it works
// - Re-map bit 0 mirrors column-to-segment order.
// - Re-map bit 1 swaps the two pixel nibbles.
// - Re-map bit 2 picks column or row increment.
// - Re-map bit 4 reverses row-to-common order.
// - Full window takes 8192 bytes, 64 per row.
// - Start line picks first row output.
// - Sequential writes stay inside column/row window.
// - Reset restores all configuration defaults.
// - Display-on command enables outputs 200 ms later.
// - Memory holds 128x128 pixels, two per byte.
// - Data port versus command port selects transfer.
module olm_frame_map #(
    parameter int SETTLE_CYC = olm_pkg::SETTLE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             panel_on,
    output logic      [6:0]  com_index,
    output logic      [5:0]  seg_pair,
    output logic      [7:0]  column_drive_output
);

    // The settle counter is 24 bits wide, so longer waits cannot be served.
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << 24)) begin : g_bad_settle
        $error("SETTLE_CYC out of range");
    end

    logic [7:0]        mem [0:8191];
    olm_pkg::olm_cfg_t cfg;
    olm_pkg::olm_cfg_t next_cfg;
    logic [5:0]        col_ptr;
    logic [5:0]        next_col_ptr;
    logic [6:0]        row_ptr;
    logic [6:0]        next_row_ptr;
    olm_pkg::olm_pwr_t pwr;
    olm_pkg::olm_pwr_t next_pwr;
    logic [23:0]       cnt;
    logic [23:0]       next_cnt;
    logic [6:0]        scan_k;
    logic [6:0]        next_scan_k;
    logic [5:0]        scan_c;
    logic [5:0]        next_scan_c;
    logic [31:0]       next_prdata;
    logic [6:0]        next_com_index;
    logic [5:0]        next_seg_pair;
    logic [7:0]        next_drive;
    logic [7:0]        rd_byte;
    logic              setup;
    logic              wr_acc;
    logic              dwr;
    logic              mapped;
    logic [5:0]        wcol;
    logic [12:0]       waddr;
    logic [7:0]        wbyte;
    logic [6:0]        srow;
    logic [6:0]        scan_k_d;
    logic [5:0]        scan_c_d;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign dwr    = wr_acc && paddr == olm_pkg::A_DATA;
    assign mapped = paddr inside {olm_pkg::A_CMD, olm_pkg::A_DATA, olm_pkg::A_REMAP,
                                  olm_pkg::A_START, olm_pkg::A_COLWIN,
                                  olm_pkg::A_ROWWIN, olm_pkg::A_STATUS};
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Mirroring and swap are applied on the way in, so the scan stays a
    // plain raster walk; together they reverse the pixel order of a row.
    assign wcol  = cfg.remap[olm_pkg::RM_COLMIR] ? ~col_ptr : col_ptr;
    assign waddr = {row_ptr, wcol};
    assign wbyte = cfg.remap[olm_pkg::RM_NIBSW] ? {pwdata[3:0], pwdata[7:4]}
                                               : pwdata[7:0];

    // Memory row for the current scan step, offset by the start line.
    assign srow = 7'(scan_k + cfg.start);

    always_ff @(posedge pclk) begin
        if (dwr) begin
            mem[waddr] <= wbyte;
        end
        rd_byte <= mem[{srow, scan_c}];
    end

    // Configuration and write pointers.
    always_comb begin
        next_cfg     = cfg;
        next_col_ptr = col_ptr;
        next_row_ptr = row_ptr;
        if (wr_acc && paddr == olm_pkg::A_REMAP) begin
            next_cfg.remap = pwdata[7:0];
        end
        if (wr_acc && paddr == olm_pkg::A_START) begin
            next_cfg.start = pwdata[6:0];
        end
        if (wr_acc && paddr == olm_pkg::A_COLWIN) begin
            next_cfg.col_s = pwdata[5:0];
            next_cfg.col_e = pwdata[olm_pkg::WIN_END_LSB +: 6];
            next_col_ptr   = pwdata[5:0];
        end
        if (wr_acc && paddr == olm_pkg::A_ROWWIN) begin
            next_cfg.row_s = pwdata[6:0];
            next_cfg.row_e = pwdata[olm_pkg::WIN_END_LSB +: 7];
            next_row_ptr   = pwdata[6:0];
        end
        if (dwr) begin
            if (!cfg.remap[olm_pkg::RM_VINC]) begin
                if (col_ptr != cfg.col_e) begin
                    next_col_ptr = col_ptr + 6'h01;
                end else begin
                    next_col_ptr = cfg.col_s;
                    next_row_ptr = (row_ptr == cfg.row_e) ? cfg.row_s
                                                           : row_ptr + 7'h01;
                end
            end else begin
                if (row_ptr != cfg.row_e) begin
                    next_row_ptr = row_ptr + 7'h01;
                end else begin
                    next_row_ptr = cfg.row_s;
                    next_col_ptr = (col_ptr == cfg.col_e) ? cfg.col_s
                                                           : col_ptr + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg.remap <= olm_pkg::REMAP_RST;
            cfg.start <= olm_pkg::START_RST;
            cfg.col_s <= olm_pkg::COL_S_RST;
            cfg.col_e <= olm_pkg::COL_E_RST;
            cfg.row_s <= olm_pkg::ROW_S_RST;
            cfg.row_e <= olm_pkg::ROW_E_RST;
            col_ptr   <= olm_pkg::COL_S_RST;
            row_ptr   <= olm_pkg::ROW_S_RST;
        end else begin
            cfg     <= next_cfg;
            col_ptr <= next_col_ptr;
            row_ptr <= next_row_ptr;
        end
    end

    // Display power state. A repeated on command does not restart the wait.
    always_comb begin
        next_pwr = pwr;
        next_cnt = cnt;
        if (wr_acc && paddr == olm_pkg::A_CMD && pwdata[7:0] == olm_pkg::CMD_OFF) begin
            next_pwr = olm_pkg::PWR_OFF;
            next_cnt = 24'h000000;
        end else begin
            case (pwr)
                olm_pkg::PWR_OFF: begin
                    if (wr_acc && paddr == olm_pkg::A_CMD
                        && pwdata[7:0] == olm_pkg::CMD_ON) begin
                        next_pwr = olm_pkg::PWR_SETTLE;
                        next_cnt = 24'(SETTLE_CYC - 1);
                    end
                end
                olm_pkg::PWR_SETTLE: begin
                    if (cnt == 24'h000000) begin
                        next_pwr = olm_pkg::PWR_ON;
                    end else begin
                        next_cnt = cnt - 24'h000001;
                    end
                end
                olm_pkg::PWR_ON: begin
                    next_pwr = olm_pkg::PWR_ON;
                end
                default: begin
                    next_pwr = olm_pkg::PWR_OFF;
                    next_cnt = 24'h000000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr <= olm_pkg::PWR_OFF;
            cnt <= 24'h000000;
        end else begin
            pwr <= next_pwr;
            cnt <= next_cnt;
        end
    end

    // Scan: 64 bytes per common line, 128 lines per frame. The memory read
    // adds one cycle, so the indices are delayed to stay with their byte.
    always_comb begin
        next_scan_c    = scan_c + 6'h01;
        next_scan_k    = (scan_c == 6'h3F) ? scan_k + 7'h01 : scan_k;
        next_seg_pair  = 6'h00;
        next_com_index = 7'h00;
        next_drive     = 8'h00;
        if (pwr == olm_pkg::PWR_ON) begin
            next_seg_pair  = scan_c_d;
            next_com_index = cfg.remap[olm_pkg::RM_COMMIR] ? ~scan_k_d : scan_k_d;
            next_drive     = rd_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_k              <= 7'h00;
            scan_c              <= 6'h00;
            scan_k_d            <= 7'h00;
            scan_c_d            <= 6'h00;
            panel_on            <= 1'b0;
            seg_pair            <= 6'h00;
            com_index           <= 7'h00;
            column_drive_output <= 8'h00;
        end else begin
            scan_k              <= next_scan_k;
            scan_c              <= next_scan_c;
            scan_k_d            <= scan_k;
            scan_c_d            <= scan_c;
            panel_on            <= pwr == olm_pkg::PWR_ON;
            seg_pair            <= next_seg_pair;
            com_index           <= next_com_index;
            column_drive_output <= next_drive;
        end
    end

    // Read data is captured in the setup cycle so it is stable in access.
    always_comb begin
        next_prdata = prdata;
        if (setup) begin
            case (paddr)
                olm_pkg::A_REMAP:  next_prdata = {24'h000000, cfg.remap};
                olm_pkg::A_START:  next_prdata = {25'h0000000, cfg.start};
                olm_pkg::A_COLWIN: next_prdata = {18'h00000, cfg.col_e, 2'h0, cfg.col_s};
                olm_pkg::A_ROWWIN: next_prdata = {17'h00000, cfg.row_e, 1'h0, cfg.row_s};
                olm_pkg::A_STATUS: next_prdata = {13'h0000, pwr, 1'h0, row_ptr,
                                                  2'h0, col_ptr};
                default:           next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hwrite;
        dwr && !cfg.remap[olm_pkg::RM_VINC];
    endsequence
    sequence s_vwrite;
        dwr && cfg.remap[olm_pkg::RM_VINC] && !(wr_acc && paddr != olm_pkg::A_DATA);
    endsequence

    chk_hinc_col: assert property (
        s_hwrite and (col_ptr != cfg.col_e) |=> col_ptr == $past(col_ptr) + 6'h01
            && row_ptr == $past(row_ptr))
        else $error("column pointer did not advance");
    chk_vinc_row: assert property (
        s_vwrite and (row_ptr != cfg.row_e) |=> row_ptr == $past(row_ptr) + 7'h01
            && col_ptr == $past(col_ptr))
        else $error("row pointer did not advance");
    chk_win_wrap: assert property (
        s_hwrite and (col_ptr == cfg.col_e) and (row_ptr != cfg.row_e)
            |=> col_ptr == cfg.col_s && row_ptr == $past(row_ptr) + 7'h01)
        else $error("window wrap wrong");
    chk_mem_store: assert property (
        dwr |=> mem[$past({row_ptr, cfg.remap[olm_pkg::RM_COLMIR] ? 6'h3F - col_ptr
                                                                     : col_ptr})]
            == $past(wbyte))
        else $error("byte stored at wrong column");
    chk_nib_swap: assert property (
        dwr && cfg.remap[olm_pkg::RM_NIBSW] |=> mem[$past(waddr)]
            == {$past(pwdata[3:0]), $past(pwdata[7:4])})
        else $error("nibbles not swapped");
    chk_com_order: assert property (
        pwr == olm_pkg::PWR_ON && $stable(cfg) && cfg.remap[olm_pkg::RM_COMMIR]
            |=> com_index == 7'h7F - $past(scan_k_d))
        else $error("common order not mirrored");
    chk_on_delay: assert property (
        $rose(panel_on) |-> $past(pwr, 2) == olm_pkg::PWR_SETTLE && $past(cnt, 2) == 0)
        else $error("outputs on before settle");
    chk_off_now: assert property (
        wr_acc && paddr == olm_pkg::A_CMD && pwdata[7:0] == olm_pkg::CMD_OFF
            |=> pwr == olm_pkg::PWR_OFF ##1 !panel_on)
        else $error("display off not taken");

endmodule

// file: rtl/olm_pkg.sv
// Constants, field layouts and types for the frame memory mapping block.
// Assumes an APB master with 32-bit data; only paddr[7:0] is decoded.
package olm_pkg;
    // Register byte offsets. Command and data ports select the transfer type.
    localparam logic [7:0] A_CMD    = 8'h00;
    localparam logic [7:0] A_DATA   = 8'h04;
    localparam logic [7:0] A_REMAP  = 8'h08;
    localparam logic [7:0] A_START  = 8'h0C;
    localparam logic [7:0] A_COLWIN = 8'h10;
    localparam logic [7:0] A_ROWWIN = 8'h14;
    localparam logic [7:0] A_STATUS = 8'h18;
    // Display command codes.
    localparam logic [7:0] CMD_ON  = 8'hAF;
    localparam logic [7:0] CMD_OFF = 8'hAE;
    // Re-map configuration bit positions.
    localparam int RM_COLMIR = 0;
    localparam int RM_NIBSW  = 1;
    localparam int RM_VINC   = 2;
    localparam int RM_COMMIR = 4;
    // Window registers: start in the low byte, end from this bit up.
    localparam int WIN_END_LSB = 8;
    // Status fields: column pointer, row pointer, power state.
    localparam int ST_ROW_LSB = 8;
    localparam int ST_PWR_LSB = 16;
    // Reset values.
    localparam logic [7:0] REMAP_RST   = 8'h00;
    localparam logic [6:0] START_RST   = 7'h00;
    localparam logic [5:0] COL_S_RST   = 6'h00;
    localparam logic [5:0] COL_E_RST   = 6'h3F;
    localparam logic [6:0] ROW_S_RST   = 7'h00;
    localparam logic [6:0] ROW_E_RST   = 7'h7F;
    // Display-on settle time and its count at the 40 MHz clock.
    localparam int SETTLE_MS  = 200;
    localparam int CLK_KHZ    = 40000;
    localparam int SETTLE_CYC = SETTLE_MS * CLK_KHZ;

    typedef struct packed {
        logic [7:0] remap;
        logic [6:0] start;
        logic [5:0] col_s;
        logic [5:0] col_e;
        logic [6:0] row_s;
        logic [6:0] row_e;
    } olm_cfg_t;

    typedef enum logic [2:0] {
        PWR_OFF    = 3'b001,
        PWR_SETTLE = 3'b010,
        PWR_ON     = 3'b100
    } olm_pwr_t;
endpackage

// file: verification/olm_host_model.sv
// Host controller model that owns the APB request lines and the panel reset.
// Assumes a single pclk domain and a slave that may stretch the access phase.
`timescale 1ns/1ps
module olm_host_model (
    input  wire logic        pclk,
    output logic             presetn,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end

    // The pulse is held over whole cycles so that it always covers the minimum width.
    task automatic reset_pulse(input int cycles);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (cycles) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Command and data transfers are told apart only by the address they use.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: verification/olm_frame_map_tb.sv
// Self-checking bench for the frame memory mapping block.
// Assumes the host model drives APB and reset; the settle count is shortened.
`timescale 1ns/1ps
module olm_frame_map_tb;
    localparam int SETTLE = 20;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        panel_on;
    logic [6:0]  com_index;
    logic [5:0]  seg_pair;
    logic [7:0]  column_drive_output;
    logic [31:0] q;
    logic        e;
    integer      bad_count;
    integer      checked;
    integer      seed;
    integer      n;
    logic [7:0]  modes [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10};

    olm_frame_map #(.SETTLE_CYC(SETTLE)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .panel_on(panel_on), .com_index(com_index),
        .seg_pair(seg_pair), .column_drive_output(column_drive_output));

    olm_host_model host (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q, e);
    endtask

    task automatic stat(input logic [5:0] c, input logic [6:0] r, input logic [2:0] p);
        host.xfer(1'b0, olm_pkg::A_STATUS, 32'h0, q, e);
        check("status", q, {13'h0, p, 1'b0, r, 2'h0, c});
        check("status error", e, 0);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
        host.xfer(1'b0, a, 32'h0, q, e);
        check(nm, q, x);
    endtask

    task automatic stream(input int cnt);
        logic [31:0] v;
        for (int i = 0; i < cnt; i++) begin
            v = $random(seed);
            wr(olm_pkg::A_DATA, {24'h0, v[7:0]});
        end
    endtask

    task automatic win(input logic [5:0] cs, input logic [5:0] ce,
                       input logic [6:0] rs, input logic [6:0] re);
        wr(olm_pkg::A_COLWIN, {18'h0, ce, 2'h0, cs});
        wr(olm_pkg::A_ROWWIN, {17'h0, re, 1'b0, rs});
    endtask

    function automatic logic [7:0] shown(input logic [7:0] b, input logic [7:0] m);
        return m[1] ? {b[3:0], b[7:4]} : b;
    endfunction

    // The scan reaches any place within one frame, so a wait of one frame plus slack suffices.
    task automatic pix(input logic [7:0] m, input logic [6:0] s, input logic [5:0] c,
                       input logic [6:0] r, input logic [7:0] b);
        logic [5:0] sg;
        logic [6:0] k;
        logic [6:0] cm;
        int         t;
        wr(olm_pkg::A_REMAP, {24'h0, m});
        wr(olm_pkg::A_START, {25'h0, s});
        win(c, 6'h3F, r, 7'h7F);
        wr(olm_pkg::A_DATA, {24'h0, b});
        sg = m[0] ? 6'h3F - c : c;
        k  = r - s;
        cm = m[4] ? 7'h7F - k : k;
        t  = 0;
        repeat (4) @(negedge pclk);
        while (!(panel_on === 1'b1 && com_index === cm && seg_pair === sg) && t < 9000) begin
            @(negedge pclk);
            t++;
        end
        check("pixel slot", t < 9000, 1);
        check("pixel byte", column_drive_output, shown(b, m));
    endtask

    // Writes take three cycles and each pixel probe up to a frame, about 70000 in all.
    initial begin
        repeat (95000) @(posedge pclk);
        bad_count++;
        summarize();
    end

    initial begin
        bad_count = 0;
        checked   = 0;
        seed      = 32'hdbd5;
        host.reset_pulse(16);
        stat(6'h00, 7'h00, 3'h1);
        host.xfer(1'b0, 8'h40, 32'h0, q, e);
        check("unmapped error", e, 1);
        check("unmapped data", q, 32'h0);
        wr(olm_pkg::A_CMD, 32'h0);
        stat(6'h00, 7'h00, 3'h1);
        n = 64 + ($random(seed) & 63);
        stream(n);
        stat(6'(n % 64), 7'(n / 64), 3'h1);
        wr(olm_pkg::A_REMAP, 32'h4);
        win(6'h00, 6'h3F, 7'h00, 7'h7F);
        stream(130);
        stat(6'h01, 7'h02, 3'h1);
        wr(olm_pkg::A_REMAP, 32'h0);
        win(6'h01, 6'h3E, 7'h01, 7'h7E);
        stat(6'h01, 7'h01, 3'h1);
        stream(62);
        stat(6'h01, 7'h02, 3'h1);
        stream(7812 - 62);
        stat(6'h01, 7'h01, 3'h1);
        wr(olm_pkg::A_CMD, {24'h0, olm_pkg::CMD_ON});
        n = 0;
        while (panel_on !== 1'b1 && n < SETTLE + 10) begin
            @(negedge pclk);
            n++;
        end
        check("settle time", n >= SETTLE - 1 && n <= SETTLE + 3, 1);
        stat(6'h01, 7'h01, 3'h4);
        for (int i = 0; i < 5; i++) begin
            pix(modes[i], (i == 4) ? 7'h78 : 7'($random(seed)), 6'($random(seed)),
                (i == 4) ? 7'h00 : 7'($random(seed)), 8'($random(seed)));
        end
        wr(olm_pkg::A_CMD, {24'h0, olm_pkg::CMD_OFF});
        repeat (3) @(negedge pclk);
        check("outputs off", {panel_on, com_index, seg_pair, column_drive_output}, 0);
        wr(olm_pkg::A_REMAP, 32'h5);
        stream(3);
        host.reset_pulse(16);
        stat(6'h00, 7'h00, 3'h1);
        rdc("remap reset", olm_pkg::A_REMAP, {24'h0, olm_pkg::REMAP_RST});
        rdc("start reset", olm_pkg::A_START, {25'h0, olm_pkg::START_RST});
        rdc("colwin reset", olm_pkg::A_COLWIN,
            {18'h0, olm_pkg::COL_E_RST, 2'h0, olm_pkg::COL_S_RST});
        rdc("rowwin reset", olm_pkg::A_ROWWIN,
            {17'h0, olm_pkg::ROW_E_RST, 1'b0, olm_pkg::ROW_S_RST});
        summarize();
    end
endmodule
